// ### design/ldsd_decoder.sv
// Serial slave command decoder of an eight-channel low-side LED driver.
// Assumes scl, sda and the address straps are asynchronous pins; the
// open-drain data pin is resolved outside from sda_out and sda_oe.
// Functional notes
// - Read after subaddress 11H returns the data shift register.
// - Write 11H loads the data byte into shift register only.
// - Write 22H copies shift register to output register, no data.
// - Write 44H loads data byte and copies it to output register.
// - Undefined subaddress changes neither register.
// - Undefined subaddress byte is not acknowledged; data pin released.
// - Address byte must be 1100, pin address bits, then read/write.
// - 22H copy happens in subaddress acknowledge; later data ignored.
// - 44H output update happens in the data byte acknowledge.
// - Reset clears interface state and both registers.
`timescale 1ns/1ns
module ldsd_decoder
  import ldsd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic [2:0] dev_addr,
  output logic sda_out,
  output logic sda_oe,
  output logic [7:0] out_data
);
  // ************************************************************
  // Pin synchronisation and bus condition detection
  // ************************************************************
  logic [LDSD_SYNC_W-1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic [2:0] addr_s;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  ldsd_sync #(.WIDTH(LDSD_SYNC_W)) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in({scl, sda_in, dev_addr}),
    .sync_out(pins_s)
  );

  assign scl_s = pins_s[4];
  assign sda_s = pins_s[3];
  assign addr_s = pins_s[2:0];
  assign scl_rise = scl_s && !scl_prev_q;
  assign scl_fall = !scl_s && scl_prev_q;
  assign bus_start = scl_s && scl_prev_q && sda_prev_q && !sda_s;
  assign bus_stop = scl_s && scl_prev_q && !sda_prev_q && sda_s;

  // ************************************************************
  // Protocol state
  // ************************************************************
  ldsd_state_t state_q;
  ldsd_state_t state_d;
  ldsd_phase_t phase_q;
  ldsd_phase_t phase_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [7:0] rx_q;
  logic [7:0] rx_d;
  logic [7:0] tx_q;
  logic [7:0] tx_d;
  logic [7:0] sub_q;
  logic [7:0] sub_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [7:0] out_q;
  logic [7:0] out_d;
  logic rw_q;
  logic rw_d;
  logic nack_q;
  logic nack_d;
  logic oe_q;
  logic oe_d;
  logic byte_end;
  logic addr_hit;
  logic sub_known;

  assign byte_end = (state_q == ST_RX) && scl_fall && (cnt_q == LDSD_RX_BITS);
  assign addr_hit = (rx_q[7:4] == LDSD_GROUP_ID) && (rx_q[3:1] == addr_s);
  assign sub_known = (rx_q == LDSD_SUB_RW) || (rx_q == LDSD_SUB_XFER) ||
                     (rx_q == LDSD_SUB_WX);

  always_comb
  begin
    state_d = state_q;
    phase_d = phase_q;
    cnt_d = cnt_q;
    rx_d = rx_q;
    tx_d = tx_q;
    sub_d = sub_q;
    shift_d = shift_q;
    out_d = out_q;
    rw_d = rw_q;
    nack_d = nack_q;
    // Start and stop override any byte in progress
    if (bus_start)
    begin
      state_d = ST_RX;
      phase_d = PH_ADDR;
      cnt_d = 4'h0;
    end
    else if (bus_stop)
    begin
      state_d = ST_IDLE;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE, ST_IGNORE:
          state_d = state_q;
        ST_RX:
        begin
          if (scl_rise && cnt_q != LDSD_RX_BITS)
          begin
            rx_d = {rx_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end
          else if (byte_end)
          begin
            unique case (phase_q)
              PH_ADDR:
              begin
                rw_d = rx_q[0];
                state_d = addr_hit ? ST_ACK : ST_IGNORE;
              end
              PH_SUB:
              begin
                sub_d = rx_q;
                state_d = sub_known ? ST_ACK : ST_IGNORE;
                if (rx_q == LDSD_SUB_XFER)
                begin
                  out_d = shift_q;
                end
              end
              default:
              begin
                if (sub_q == LDSD_SUB_XFER)
                begin
                  state_d = ST_IGNORE;
                end
                else
                begin
                  state_d = ST_ACK;
                  shift_d = rx_q;
                  if (sub_q == LDSD_SUB_WX)
                  begin
                    out_d = rx_q;
                  end
                end
              end
            endcase
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            cnt_d = 4'h0;
            if (phase_q == PH_ADDR && rw_q)
            begin
              state_d = ST_TX;
              // Only a selected 11H yields data; otherwise the pin stays free
              tx_d = (sub_q == LDSD_SUB_RW) ? shift_q : LDSD_IDLE_BYTE;
            end
            else
            begin
              state_d = ST_RX;
              phase_d = (phase_q == PH_ADDR) ? PH_SUB : PH_DATA;
            end
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            tx_d = {tx_q[6:0], 1'b1};
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == LDSD_TX_LAST)
            begin
              state_d = ST_MACK;
            end
          end
        end
        ST_MACK:
        begin
          if (scl_rise)
          begin
            nack_d = sda_s;
          end
          else if (scl_fall)
          begin
            cnt_d = 4'h0;
            state_d = nack_q ? ST_IGNORE : ST_TX;
            tx_d = (sub_q == LDSD_SUB_RW) ? shift_q : LDSD_IDLE_BYTE;
          end
        end
        default:
        begin
          state_d = ST_IDLE;
        end
      endcase
    end
    // Drive low only for an acknowledge or a zero data bit
    oe_d = (state_d == ST_ACK) || (state_d == ST_TX && !tx_d[7]);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      state_q <= ST_IDLE;
      phase_q <= PH_ADDR;
      cnt_q <= 4'h0;
      rx_q <= LDSD_REG_RST;
      tx_q <= LDSD_IDLE_BYTE;
      sub_q <= LDSD_REG_RST;
      shift_q <= LDSD_REG_RST;
      out_q <= LDSD_REG_RST;
      rw_q <= 1'b0;
      nack_q <= 1'b1;
      oe_q <= 1'b0;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      sub_q <= sub_d;
      shift_q <= shift_d;
      out_q <= out_d;
      rw_q <= rw_d;
      nack_q <= nack_d;
      oe_q <= oe_d;
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  // Open-drain: the data value is a constant low, only the enable moves
  assign sda_out = 1'b0;
  assign sda_oe = oe_q;
  assign out_data = out_q;

  // ************************************************************
  // Checks
  // ************************************************************
  sequence sub_end_s;
    byte_end && phase_q == PH_SUB;
  endsequence
  sequence data_end_s;
    byte_end && phase_q == PH_DATA;
  endsequence

  read_data_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    state_q == ST_ACK && scl_fall && phase_q == PH_ADDR && rw_q &&
    sub_q == LDSD_SUB_RW |=> state_q == ST_TX && tx_q == $past(shift_q))
    else $error("read byte is not the shift register");
  write_only_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    data_end_s ##0 (sub_q == LDSD_SUB_RW) |=>
    shift_q == $past(rx_q) && $stable(out_q) && oe_q)
    else $error("plain write changed output or missed shift");
  xfer_copy_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    sub_end_s ##0 (rx_q == LDSD_SUB_XFER) |=>
    out_q == $past(shift_q) && state_q == ST_ACK && oe_q)
    else $error("transfer did not copy at subaddress acknowledge");
  write_xfer_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    data_end_s ##0 (sub_q == LDSD_SUB_WX) |=>
    out_q == $past(rx_q) && shift_q == $past(rx_q) && oe_q)
    else $error("write and transfer failed at data acknowledge");
  undef_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    state_q == ST_IGNORE && !bus_start |=> $stable(shift_q) && $stable(out_q))
    else $error("registers changed while ignoring");
  undef_nack_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    sub_end_s ##0 !sub_known |=> (state_q == ST_IGNORE && !oe_q) [*2])
    else $error("undefined subaddress was acknowledged");
  addr_match_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    byte_end && phase_q == PH_ADDR |=> (state_q == ST_ACK) == $past(addr_hit))
    else $error("address decision wrong");
  xfer_data_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    data_end_s ##0 (sub_q == LDSD_SUB_XFER) |=>
    state_q == ST_IGNORE && !oe_q && $stable(shift_q))
    else $error("data after transfer command was taken");
  reset_clear_a: assert property (@(posedge ref_clk) disable iff (1'b0)
    !resetn |=> out_data == LDSD_REG_RST && !sda_oe && state_q == ST_IDLE)
    else $error("reset did not clear outputs");
endmodule

// ### design/ldsd_pkg.sv
// Constants and types for the LED driver serial command decoder,
// together with the small pin synchroniser the decoder instantiates.
// Assumes one free-running clock and a synchronous active-low reset.
`timescale 1ns/1ns
package ldsd_pkg;
  // ************************************************************
  // Address and command codes
  // ************************************************************
  localparam logic [3:0] LDSD_GROUP_ID = 4'hC;
  localparam logic [7:0] LDSD_SUB_RW = 8'h11;
  localparam logic [7:0] LDSD_SUB_XFER = 8'h22;
  localparam logic [7:0] LDSD_SUB_WX = 8'h44;
  // ************************************************************
  // Reset values and counts
  // ************************************************************
  localparam logic [7:0] LDSD_REG_RST = 8'h00;
  localparam logic [7:0] LDSD_IDLE_BYTE = 8'hFF;
  localparam logic [3:0] LDSD_RX_BITS = 4'h8;
  localparam logic [3:0] LDSD_TX_LAST = 4'h7;
  localparam int LDSD_SYNC_W = 5;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_ACK = 3'b010,
    ST_TX = 3'b011,
    ST_MACK = 3'b100,
    ST_IGNORE = 3'b101
  } ldsd_state_t;

  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_SUB = 2'b01,
    PH_DATA = 2'b10
  } ldsd_phase_t;
endpackage

module ldsd_sync
  import ldsd_pkg::*;
#(
  parameter int WIDTH = LDSD_SYNC_W
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // Pins idle high, so both stages reset high to avoid a false start
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      meta_q <= '1;
      sync_q <= '1;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// ### tb/ldsd_master.sv
// Serial bus controller model: start, stop, byte write and byte read.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ns
module ldsd_master
(
  input wire logic ref_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  // Clock stands high and data is released outside frames
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // Quarter of the 80 ns link period
  task automatic q;
    repeat (2) @(negedge ref_clk);
  endtask

  // Extra quarter lets a slave finish releasing data before a restart
  task automatic start;
    sda_drv = 1'b1;
    q;
    q;
    scl = 1'b1;
    q;
    sda_drv = 1'b0;
    q;
    scl = 1'b0;
    q;
  endtask

  task automatic stop;
    sda_drv = 1'b0;
    q;
    scl = 1'b1;
    q;
    sda_drv = 1'b1;
    q;
    q;
  endtask

  task automatic xbit(input logic b, output logic r);
    sda_drv = b;
    q;
    scl = 1'b1;
    q;
    r = sda;
    q;
    scl = 1'b0;
    q;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      xbit(d[i], r);
    xbit(1'b1, r);
    ack = ~r;
  endtask

  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      xbit(1'b1, d[i]);
    xbit(~mack, r);
  endtask
endmodule

// ### tb/test_ldsd_decoder.sv
// Self-checking bench for the LED driver serial command decoder.
// Assumes the controller model in ldsd_master and the design package.
`timescale 1ns/1ns
module test_ldsd_decoder
  import ldsd_pkg::*;
;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] dev_addr = 3'h0;
  logic scl, m_sda, sda_w, sda_out, sda_oe;
  logic [7:0] out_data, d;
  logic [7:0] exp_q[$];
  logic [7:0] got_q[$];
  logic [7:0] exp_out_q[$];
  logic [7:0] last_out = 8'h00;
  logic [7:0] e_out;
  logic [7:0] bad[8] = '{8'h00, 8'h10, 8'h12, 8'h21,
                         8'h33, 8'h45, 8'h88, 8'hFF};
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;

  always #5 ref_clk = ~ref_clk;
  assign sda_w = m_sda & ~(sda_oe & ~sda_out);

  ldsd_decoder DUT (.ref_clk(ref_clk), .resetn(resetn), .scl(scl),
    .sda_in(sda_w), .dev_addr(dev_addr), .sda_out(sda_out),
    .sda_oe(sda_oe), .out_data(out_data));
  ldsd_master bfm (.ref_clk(ref_clk), .sda(sda_w), .scl(scl),
    .sda_drv(m_sda));

  // ************************************************************
  // Result checking
  // ************************************************************
  task automatic note(input logic [7:0] e, input logic [7:0] g);
    exp_q.push_back(e);
    got_q.push_back(g);
  endtask

  task automatic cmp(input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  endtask

  always @(negedge ref_clk)
    while (got_q.size() > 0)
      cmp(exp_q.pop_front(), got_q.pop_front());

  // Any output register change that was not announced counts as a miss
  always @(negedge ref_clk)
    if (out_data !== last_out)
    begin
      e_out = (exp_out_q.size() > 0) ? exp_out_q.pop_front() : last_out;
      cmp(e_out, out_data);
      last_out = out_data;
    end

  task automatic summarize;
    $display("compares %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Cut a hang short well past the expected run length
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      miscompares++;
      summarize;
    end
  end

  // ************************************************************
  // Transactions
  // ************************************************************
  function automatic logic [7:0] adr(input logic rw);
    return {LDSD_GROUP_ID, dev_addr, rw};
  endfunction

  // Output register sampled after the subaddress and after the data ack
  task automatic cmd(input logic [7:0] a, s, dt, input logic [2:0] ea,
                     input logic [7:0] e1, e2);
    logic [2:0] ak;
    logic [7:0] o1, o2;
    bfm.start;
    bfm.wbyte(a, ak[2]);
    bfm.wbyte(s, ak[1]);
    o1 = out_data;
    bfm.wbyte(dt, ak[0]);
    o2 = out_data;
    bfm.stop;
    note({5'h00, ea}, {5'h00, ak});
    note(e1, o1);
    note(e2, o2);
  endtask

  task automatic chkrd(input logic [7:0] e);
    logic a;
    logic [7:0] v;
    logic [7:0] w;
    bfm.start;
    bfm.wbyte(adr(1'b0), a);
    bfm.wbyte(LDSD_SUB_RW, a);
    bfm.start;
    bfm.wbyte(adr(1'b1), a);
    // Acknowledging the first byte makes the design send the register again
    bfm.rbyte(1'b1, v);
    bfm.rbyte(1'b0, w);
    bfm.stop;
    note(e, v);
    note(e, w);
  endtask

  initial
  begin
    void'($urandom(32'h80CFF2D0));
    repeat (10) @(negedge ref_clk);
    dev_addr = 3'($urandom);
    resetn = 1'b1;
    repeat (3) @(negedge ref_clk);
    note(LDSD_REG_RST, out_data);
    chkrd(LDSD_REG_RST);
    $display("test reset done");
    // Keep d and ~d off zero so every expected output change is visible
    d = {1'b0, 7'($urandom)} | 8'h01;
    cmd(adr(1'b0), LDSD_SUB_RW, d, 3'h7, 8'h00, 8'h00);
    chkrd(d);
    exp_out_q.push_back(d);
    cmd(adr(1'b0), LDSD_SUB_XFER, ~d, 3'h6, d, d);
    chkrd(d);
    $display("test load and transfer done");
    exp_out_q.push_back(~d);
    cmd(adr(1'b0), LDSD_SUB_WX, ~d, 3'h7, d, ~d);
    d = ~d;
    chkrd(d);
    $display("test write and transfer done");
    foreach (bad[i])
      cmd(adr(1'b0), bad[i], 8'($urandom), 3'h4, d, d);
    chkrd(d);
    $display("test undefined codes done");
    cmd({4'hD, dev_addr, 1'b0}, LDSD_SUB_WX, ~d, 3'h0, d, d);
    cmd({LDSD_GROUP_ID, ~dev_addr, 1'b0}, LDSD_SUB_RW, ~d,
        3'h0, d, d);
    chkrd(d);
    $display("test foreign address done");
    exp_out_q.push_back(LDSD_REG_RST);
    resetn = 1'b0;
    repeat (3) @(negedge ref_clk);
    note(LDSD_REG_RST, out_data);
    resetn = 1'b1;
    repeat (3) @(negedge ref_clk);
    chkrd(LDSD_REG_RST);
    $display("test second reset done");
    repeat (2) @(negedge ref_clk);
    cmp(8'(exp_out_q.size()), 8'h00);
    summarize;
  end
endmodule
